// ### core/rssd_datapath.sv
module rssd_datapath (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	// Operation request from the fetch sequencer
	input  wire logic                 op_valid_i,
	input  wire rssd_pkg::rssd_op_t   op_i,
	input  wire logic [2:0]           bit_sel_i,
	input  wire logic [7:0]           imm_i,
	// Data memory read data for the addressed byte
	input  wire logic [7:0]           mem_rdata_i,
	// Data memory write port
	output logic                      mem_we_o,
	output logic      [7:0]           mem_wdata_o,
	// Architectural state
	output logic      [7:0]           accum_o,
	output logic                      carry_o,
	output logic                      nibble_half_flag_o,
	output logic                      signed_range_flag_o,
	output logic                      zero_o,
	// Sequencer feedback
	output logic                      busy_o,
	output logic                      skip_next_o
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_ff;
	logic rst_sync_ff;

	// Two flops so reset release is seen by every flop on the same edge.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] acc;
		logic       c;
		logic       half;
		logic       sflow;
		logic       z;
		logic       we;
		logic [7:0] wdata;
	} rssd_state_t;

	rssd_state_t st_ff;
	rssd_state_t nxt_st;

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic logic is_skip_op(input rssd_pkg::rssd_op_t op);
		is_skip_op = (op == rssd_pkg::OP_DEC_THEN_SKIP_IF_NULL)
			|| (op == rssd_pkg::OP_DEC_THEN_SKIP_TO_ACCUM)
			|| (op == rssd_pkg::OP_INC_THEN_SKIP_IF_NULL)
			|| (op == rssd_pkg::OP_INC_THEN_SKIP_TO_ACCUM)
			|| (op == rssd_pkg::OP_BIT_SKIP_IF_HIGH);
	endfunction : is_skip_op

	function automatic logic is_sub_op(input rssd_pkg::rssd_op_t op);
		is_sub_op = (op == rssd_pkg::OP_MINUS_WITH_BORROW)
			|| (op == rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM)
			|| (op == rssd_pkg::OP_MINUS)
			|| (op == rssd_pkg::OP_MINUS_TO_MEM)
			|| (op == rssd_pkg::OP_MINUS_IMM);
	endfunction : is_sub_op

	// ----------------------------------------
	// Subtractor
	// ----------------------------------------
	logic [7:0] sub_b;
	logic       sub_borrow;
	logic [7:0] sub_diff;
	logic       sub_c;
	logic       sub_half;
	logic       sub_sflow;
	logic       sub_z;

	// Operand select: immediate only for the immediate form.
	// immediate operand select
	assign sub_b = (op_i == rssd_pkg::OP_MINUS_IMM) ? imm_i : mem_rdata_i;

	// Borrow in is the inverted carry for the borrow forms only.
	// inverted carry borrow
	assign sub_borrow = ((op_i == rssd_pkg::OP_MINUS_WITH_BORROW)
		|| (op_i == rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM)) ? ~st_ff.c : 1'b0;

	rssd_sub u_sub (
		.a_i         (st_ff.acc),
		.b_i         (sub_b),
		.borrow_in_i (sub_borrow),
		.diff_o      (sub_diff),
		.carry_o     (sub_c),
		.half_o      (sub_half),
		.ovf_o       (sub_sflow),
		.zero_o      (sub_z)
	);

	// ----------------------------------------
	// Skip sequencing
	// ----------------------------------------
	logic       skip_cond;
	logic       skip_start;
	logic [7:0] mem_dec;
	logic [7:0] mem_inc;
	logic       sel_bit;

	assign mem_dec = mem_rdata_i - 8'h01;
	assign mem_inc = mem_rdata_i + 8'h01;
	assign sel_bit = mem_rdata_i[bit_sel_i];

	// Skip condition per operation, judged on the new value.
	always_comb begin
		skip_cond = 1'b0;
		unique case (op_i)
			rssd_pkg::OP_DEC_THEN_SKIP_IF_NULL: skip_cond = (mem_dec == 8'h00);
			rssd_pkg::OP_DEC_THEN_SKIP_TO_ACCUM: skip_cond = (mem_dec == 8'h00);
			rssd_pkg::OP_INC_THEN_SKIP_IF_NULL: skip_cond = (mem_inc == 8'h00);
			rssd_pkg::OP_INC_THEN_SKIP_TO_ACCUM: skip_cond = (mem_inc == 8'h00);
			rssd_pkg::OP_BIT_SKIP_IF_HIGH: skip_cond = sel_bit;
			default: skip_cond = 1'b0;
		endcase
	end

	// Requests arriving during the dummy cycle are ignored.
	assign skip_start = op_valid_i && !busy_o && is_skip_op(op_i);

	rssd_skip_ctl u_skip (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_sync_ff),
		.start_i (skip_start),
		.cond_i  (skip_cond),
		.busy_o  (busy_o),
		.skip_o  (skip_next_o)
	);

	// ----------------------------------------
	// Operation execution
	// ----------------------------------------
	logic accept;

	assign accept = op_valid_i && !busy_o;

	// Next state: write strobe lasts one cycle; flags move only where stated.
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.we = 1'b0;
		if (accept) begin
			unique case (op_i)
				rssd_pkg::OP_ROTATE_LEFT_THRU_FLAG_MEM: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = {mem_rdata_i[6:0], st_ff.c};
					nxt_st.c     = mem_rdata_i[rssd_pkg::RSSD_MSB];
				end
				rssd_pkg::OP_ROTATE_LEFT_THRU_FLAG_TO_ACCUM: begin
					nxt_st.acc = {mem_rdata_i[6:0], st_ff.c};
					nxt_st.c   = mem_rdata_i[rssd_pkg::RSSD_MSB];
				end
				rssd_pkg::OP_ROTATE_RIGHT_MEM: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = {mem_rdata_i[0], mem_rdata_i[7:1]};
				end
				rssd_pkg::OP_ROTATE_RIGHT_TO_ACCUM: begin
					nxt_st.acc = {mem_rdata_i[0], mem_rdata_i[7:1]};
				end
				rssd_pkg::OP_ROTATE_RIGHT_THRU_FLAG_MEM: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = {st_ff.c, mem_rdata_i[7:1]};
					nxt_st.c     = mem_rdata_i[0];
				end
				rssd_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_ACCUM: begin
					nxt_st.acc = {st_ff.c, mem_rdata_i[7:1]};
					nxt_st.c   = mem_rdata_i[0];
				end
				rssd_pkg::OP_MINUS_WITH_BORROW,
				rssd_pkg::OP_MINUS,
				rssd_pkg::OP_MINUS_IMM: begin
					nxt_st.acc = sub_diff;
				end
				rssd_pkg::OP_MINUS_WITH_BORROW_TO_MEM,
				rssd_pkg::OP_MINUS_TO_MEM: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = sub_diff;
				end
				rssd_pkg::OP_DEC_THEN_SKIP_IF_NULL: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = mem_dec;
				end
				rssd_pkg::OP_DEC_THEN_SKIP_TO_ACCUM: begin
					nxt_st.acc = mem_dec;
				end
				rssd_pkg::OP_INC_THEN_SKIP_IF_NULL: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = mem_inc;
				end
				rssd_pkg::OP_INC_THEN_SKIP_TO_ACCUM: begin
					nxt_st.acc = mem_inc;
				end
				rssd_pkg::OP_SET_BYTE: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = rssd_pkg::RSSD_ALL_ONES;
				end
				rssd_pkg::OP_SET_BIT: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = mem_rdata_i | (8'h01 << bit_sel_i);
				end
				rssd_pkg::OP_SWAP_NIBBLES: begin
					nxt_st.we    = 1'b1;
					nxt_st.wdata = {mem_rdata_i[3:0],
						mem_rdata_i[rssd_pkg::RSSD_MSB:rssd_pkg::RSSD_NIB_HI]};
				end
				default: begin
					nxt_st.we = 1'b0;
				end
			endcase
			// Every subtraction refreshes all four arithmetic flags.
			// carry from inverted borrow out
			if (is_sub_op(op_i)) begin
				nxt_st.c     = sub_c;
				nxt_st.half  = sub_half;
				nxt_st.sflow = sub_sflow;
				nxt_st.z     = sub_z;
			end
		end
	end

	// State register; the synchronised reset copy clears it.
	always_ff @(posedge mclk_i or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			st_ff.acc   <= rssd_pkg::RSSD_ACC_RST;
			st_ff.c     <= rssd_pkg::RSSD_FLAG_RST;
			st_ff.half  <= rssd_pkg::RSSD_FLAG_RST;
			st_ff.sflow <= rssd_pkg::RSSD_FLAG_RST;
			st_ff.z     <= rssd_pkg::RSSD_FLAG_RST;
			st_ff.we    <= 1'b0;
			st_ff.wdata <= 8'h00;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign mem_we_o            = st_ff.we;
	assign mem_wdata_o         = st_ff.wdata;
	assign accum_o             = st_ff.acc;
	assign carry_o             = st_ff.c;
	assign nibble_half_flag_o  = st_ff.half;
	assign signed_range_flag_o = st_ff.sflow;
	assign zero_o              = st_ff.z;

endmodule : rssd_datapath

// ### core/rssd_skip_ctl.sv
// ----------------------------------------
// Two-cycle skip sequencer
// ----------------------------------------
module rssd_skip_ctl (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	// Request
	input  wire logic start_i,
	input  wire logic cond_i,
	// Status
	output logic      busy_o,
	output logic      skip_o
);
	typedef struct packed {
		logic [1:0] cnt;
		logic       skip;
	} rssd_skip_st_t;

	rssd_skip_st_t st_ff;
	rssd_skip_st_t nxt_st;

	// Count the machine cycles of a skip operation; second cycle is the dummy.
	always_comb begin
		nxt_st = st_ff;
		if (st_ff.cnt != 2'h0) begin
			nxt_st.cnt = st_ff.cnt - 2'h1;
		end else if (start_i) begin
			nxt_st.cnt  = rssd_pkg::RSSD_SKIP_CYCLES - 2'h1;
			nxt_st.skip = cond_i;
		end
		if (nxt_st.cnt == 2'h0) begin
			nxt_st.skip = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy_o = (st_ff.cnt != 2'h0);
	assign skip_o = st_ff.skip;
endmodule : rssd_skip_ctl

// ### core/rssd_sub.sv
// ----------------------------------------
// Eight-bit subtractor with flag outputs
// ----------------------------------------
module rssd_sub (
	// Operands
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] b_i,
	input  wire logic       borrow_in_i,
	// Results
	output logic      [7:0] diff_o,
	output logic            carry_o,
	output logic            half_o,
	output logic            ovf_o,
	output logic            zero_o
);
	logic [8:0] full;
	logic [4:0] low;

	// Carry is the inverted borrow: one means no borrow out.
	always_comb begin
		full    = {1'b0, a_i} - {1'b0, b_i} - {8'h00, borrow_in_i};
		low     = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, borrow_in_i};
		diff_o  = full[7:0];
		carry_o = ~full[8];
		half_o  = ~low[4];
		ovf_o   = (a_i[7] ^ b_i[7]) & (a_i[7] ^ full[7]);
		zero_o  = (full[7:0] == 8'h00);
	end
endmodule : rssd_sub

// ### pkg/rssd_pkg.sv
package rssd_pkg;

	// ----------------------------------------
	// Operation codes presented by the sequencer
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_NONE                            = 5'h00,
		OP_ROTATE_LEFT_THRU_FLAG_MEM       = 5'h01,
		OP_ROTATE_LEFT_THRU_FLAG_TO_ACCUM  = 5'h02,
		OP_ROTATE_RIGHT_MEM                = 5'h03,
		OP_ROTATE_RIGHT_TO_ACCUM           = 5'h04,
		OP_ROTATE_RIGHT_THRU_FLAG_MEM      = 5'h05,
		OP_ROTATE_RIGHT_THRU_FLAG_TO_ACCUM = 5'h06,
		OP_MINUS_WITH_BORROW               = 5'h07,
		OP_MINUS_WITH_BORROW_TO_MEM        = 5'h08,
		OP_MINUS                           = 5'h09,
		OP_MINUS_TO_MEM                    = 5'h0a,
		OP_MINUS_IMM                       = 5'h0b,
		OP_DEC_THEN_SKIP_IF_NULL           = 5'h0c,
		OP_DEC_THEN_SKIP_TO_ACCUM          = 5'h0d,
		OP_INC_THEN_SKIP_IF_NULL           = 5'h0e,
		OP_INC_THEN_SKIP_TO_ACCUM          = 5'h0f,
		OP_BIT_SKIP_IF_HIGH                = 5'h10,
		OP_SET_BYTE                        = 5'h11,
		OP_SET_BIT                         = 5'h12,
		OP_SWAP_NIBBLES                    = 5'h13
	} rssd_op_t;

	// ----------------------------------------
	// Reset values and figures
	// ----------------------------------------
	localparam logic [7:0] RSSD_ACC_RST     = 8'h00;
	localparam logic       RSSD_FLAG_RST    = 1'b0;
	localparam logic [7:0] RSSD_ALL_ONES    = 8'hff;
	localparam logic [1:0] RSSD_SKIP_CYCLES = 2'h2;
	localparam int         RSSD_MSB         = 7;
	localparam int         RSSD_NIB_HI      = 4;

endpackage : rssd_pkg

// ### test/rssd_chk_sva.sv
// ----------------------------------------
// Port checker for the datapath
// ----------------------------------------
module rssd_chk_sva (
	input wire logic               mclk_i,
	input wire logic               rst_n_i,
	input wire logic               op_valid_i,
	input wire rssd_pkg::rssd_op_t op_i,
	input wire logic [2:0]         bit_sel_i,
	input wire logic [7:0]         imm_i,
	input wire logic [7:0]         mem_rdata_i,
	input wire logic               mem_we_o,
	input wire logic [7:0]         mem_wdata_o,
	input wire logic [7:0]         accum_o,
	input wire logic               carry_o,
	input wire logic               nibble_half_flag_o,
	input wire logic               signed_range_flag_o,
	input wire logic               zero_o,
	input wire logic               busy_o,
	input wire logic               skip_next_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       take;
	logic       skop;
	logic [3:0] flg;
	logic [7:0] rd_ff;
	logic [7:0] acc_ff;
	logic       c_ff;
	logic       bit_ff;
	// Operands as they stood at the accepting edge.
	assign take = op_valid_i && !busy_o;
	assign skop = op_i inside {[5'h0c:5'h10]};
	assign flg = {carry_o, zero_o, nibble_half_flag_o, signed_range_flag_o};
	// Copies of the operands, so consequents need no nested past values.
	always_ff @(posedge mclk_i) begin
		rd_ff  <= mem_rdata_i;
		acc_ff <= accum_o;
		c_ff   <= carry_o;
		bit_ff <= mem_rdata_i[bit_sel_i];
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	rot_left_mem_a: assert property (take && op_i == rssd_pkg::OP_ROTATE_LEFT_THRU_FLAG_MEM
		|=> mem_we_o && mem_wdata_o == {rd_ff[6:0], c_ff} && carry_o == rd_ff[7])
		else $error("left rotate through carry wrong");
	rot_right_mem_a: assert property (take && op_i == rssd_pkg::OP_ROTATE_RIGHT_MEM
		|=> mem_we_o && mem_wdata_o == {rd_ff[0], rd_ff[7:1]} && $stable(flg))
		else $error("right rotate wrong");
	rot_acc_a: assert property (take && op_i == rssd_pkg::OP_ROTATE_RIGHT_THRU_FLAG_TO_ACCUM
		|=> !mem_we_o && accum_o == {c_ff, rd_ff[7:1]} && carry_o == rd_ff[0])
		else $error("right rotate through carry to accumulator wrong");
	sub_carry_a: assert property (take && op_i == rssd_pkg::OP_MINUS
		|=> carry_o == (acc_ff >= rd_ff) && zero_o == (acc_ff == rd_ff) && accum_o == acc_ff - rd_ff)
		else $error("subtract result or carry wrong");
	skip_len_a: assert property (take && skop |=> busy_o ##1 !busy_o)
		else $error("skip operation length wrong");
	skip_flags_a: assert property (take && skop |=> $stable(flg))
		else $error("skip operation changed a flag");
	bit_skip_a: assert property (take && op_i == rssd_pkg::OP_BIT_SKIP_IF_HIGH
		|=> !mem_we_o && skip_next_o == bit_ff)
		else $error("bit test skip wrong");
	dec_skip_a: assert property (take && op_i == rssd_pkg::OP_DEC_THEN_SKIP_IF_NULL
		|=> mem_we_o && mem_wdata_o == rd_ff - 8'h01 && skip_next_o == (rd_ff == 8'h01))
		else $error("decrement skip wrong");
	set_byte_a: assert property (take && op_i == rssd_pkg::OP_SET_BYTE
		|=> mem_we_o && mem_wdata_o == rssd_pkg::RSSD_ALL_ONES && $stable(flg))
		else $error("byte set wrong");
endmodule : rssd_chk_sva

// ### test/rssd_mem_model.sv
// ----------------------------------------
// Addressed data memory byte
// ----------------------------------------
module rssd_mem_model (
	// Clock
	input  wire logic       mclk_i,
	// Preload port, used by the bench to seed the byte
	input  wire logic       load_i,
	input  wire logic [7:0] load_data_i,
	// Write port
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	// Read data
	output logic      [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] byte_ff;
	// A strobed write lands on the next edge; a preload wins so the seed is exact.
	always_ff @(posedge mclk_i) begin
		if (load_i) begin
			byte_ff <= load_data_i;
		end else if (we_i) begin
			byte_ff <= wdata_i;
		end
	end
	assign rdata_o = byte_ff;
endmodule : rssd_mem_model

// ### test/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic               mclk_i;
	logic               rst_n_i;
	logic               op_valid_i;
	rssd_pkg::rssd_op_t op_i;
	logic [2:0]         bit_sel_i;
	logic [7:0]         imm_i;
	logic [7:0]         mem_rdata_i;
	logic               mem_we_o;
	logic [7:0]         mem_wdata_o;
	logic [7:0]         accum_o;
	logic               carry_o;
	logic               nibble_half_flag_o;
	logic               signed_range_flag_o;
	logic               zero_o;
	logic               busy_o;
	logic               skip_next_o;
	logic [7:0]         e_acc;
	logic [7:0]         e_mem;
	logic [3:0]         e_flg;
	logic               mem_load;
	logic [7:0]         mem_seed;
	int                 err_count;
	int                 n_checks;
	rssd_datapath i_dut (.mclk_i, .rst_n_i, .op_valid_i, .op_i, .bit_sel_i, .imm_i,
		.mem_rdata_i, .mem_we_o, .mem_wdata_o, .accum_o, .carry_o, .nibble_half_flag_o,
		.signed_range_flag_o, .zero_o, .busy_o, .skip_next_o);
	rssd_mem_model i_mem (.mclk_i, .load_i(mem_load), .load_data_i(mem_seed), .we_i(mem_we_o),
		.wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	// Free-running system clock.
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk
	// One operation: predict, issue for one edge, then judge two cycles.
	task automatic run_op(input rssd_pkg::rssd_op_t op, input logic [7:0] m, input logic [2:0] bs);
		logic [8:0] d;
		logic [4:0] h;
		logic [7:0] r;
		logic       bi;
		logic       we;
		logic       bz;
		bi = (op inside {5'h07, 5'h08}) ? !e_flg[3] : 1'b0;
		d = {1'b0, e_acc} - {1'b0, m} - 9'(bi);
		h = {1'b0, e_acc[3:0]} - {1'b0, m[3:0]} - 5'(bi);
		r = m;
		case (op)
			5'h01, 5'h02: {e_flg[3], r} = {m, e_flg[3]};
			5'h03, 5'h04: r = {m[0], m[7:1]};
			5'h05, 5'h06: {r, e_flg[3]} = {e_flg[3], m};
			5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b: begin
				r = d[7:0];
				e_flg = {!d[8], r == 8'h00, !h[4], (e_acc[7] != m[7]) && (r[7] != e_acc[7])};
			end
			5'h0c, 5'h0d: r = m - 8'h01;
			5'h0e, 5'h0f: r = m + 8'h01;
			5'h11: r = 8'hff;
			5'h12: r[bs] = 1'b1;
			5'h13: r = {m[3:0], m[7:4]};
			default: r = m;
		endcase
		bz = op inside {[5'h0c:5'h10]};
		we = op inside {5'h01, 5'h03, 5'h05, 5'h08, 5'h0a, 5'h0c, 5'h0e, [5'h11:5'h13]};
		if (op inside {5'h02, 5'h04, 5'h06, 5'h07, 5'h09, 5'h0b, 5'h0d, 5'h0f}) begin
			e_acc = r;
		end
		e_mem = we ? r : m;
		@(posedge mclk_i);
		#1;
		{mem_load, mem_seed} = {1'b1, m};
		@(posedge mclk_i);
		#1;
		mem_load = 1'b0;
		op_i = op;
		{op_valid_i, bit_sel_i, imm_i} = {1'b1, bs, m};
		@(posedge mclk_i);
		#1;
		op_valid_i = 1'b0;
		chk("write strobe", we, mem_we_o);
		chk("accumulator", e_acc, accum_o);
		chk("flags", e_flg, {carry_o, zero_o, nibble_half_flag_o, signed_range_flag_o});
		chk("busy", bz, busy_o);
		chk("skip", (op == 5'h10) ? m[bs] : bz && r == 8'h00, skip_next_o);
		@(posedge mclk_i);
		#1;
		chk("idle", 8'h00, {busy_o, skip_next_o, mem_we_o});
		chk("memory byte", e_mem, mem_rdata_i);
	endtask : run_op
	// A request held through the dummy cycle must be dropped without effect.
	task automatic t_refuse;
		@(posedge mclk_i);
		#1;
		{mem_load, mem_seed} = {1'b1, 8'h00};
		@(posedge mclk_i);
		#1;
		mem_load = 1'b0;
		op_i = rssd_pkg::OP_DEC_THEN_SKIP_TO_ACCUM;
		op_valid_i = 1'b1;
		@(posedge mclk_i);
		#1;
		op_i = rssd_pkg::OP_SET_BYTE;
		chk("dummy busy", 8'h01, busy_o);
		@(posedge mclk_i);
		#1;
		op_valid_i = 1'b0;
		chk("refused write", 8'h00, mem_we_o);
		chk("refused memory", 8'h00, mem_rdata_i);
		chk("skip accumulator", 8'hff, accum_o);
		$display("test refuse done");
	endtask : t_refuse
	task automatic t_rot;
		run_op(rssd_pkg::OP_MINUS_IMM, 8'h00, 3'h0);
		for (int k = 1; k <= 6; k++) begin
			run_op(rssd_pkg::rssd_op_t'(5'(k)), 8'h81, 3'h0);
			run_op(rssd_pkg::rssd_op_t'(5'(k)), 8'h7e, 3'h0);
		end
		$display("test rotates done");
	endtask : t_rot
	task automatic t_sub;
		logic [15:0] tbl [6] = '{16'h0507, 16'h8001, 16'h1001, 16'h7fff, 16'h3c3c, 16'h0001};
		for (int i = 0; i < 6; i++) begin
			for (int k = 7; k <= 11; k++) begin
				run_op(rssd_pkg::OP_ROTATE_RIGHT_TO_ACCUM, {tbl[i][14:8], tbl[i][15]}, 3'h0);
				run_op(rssd_pkg::rssd_op_t'(5'(k)), tbl[i][7:0], 3'h0);
			end
		end
		$display("test subtract done");
	endtask : t_sub
	task automatic t_skip;
		logic [7:0] v [5] = '{8'h00, 8'h01, 8'hff, 8'h7f, 8'h80};
		for (int i = 0; i < 5; i++) begin
			for (int k = 12; k <= 15; k++) begin
				run_op(rssd_pkg::rssd_op_t'(5'(k)), v[i], 3'h0);
			end
		end
		for (int b = 0; b < 8; b++) begin
			run_op(rssd_pkg::OP_BIT_SKIP_IF_HIGH, 8'ha5, 3'(b));
			run_op(rssd_pkg::OP_SET_BIT, 8'h12, 3'(b));
		end
		$display("test skip and bit done");
	endtask : t_skip
	task automatic t_misc;
		run_op(rssd_pkg::OP_SET_BYTE, 8'h00, 3'h0);
		run_op(rssd_pkg::OP_SWAP_NIBBLES, 8'h3c, 3'h0);
		run_op(rssd_pkg::OP_NONE, 8'h55, 3'h0);
		$display("test misc done");
	endtask : t_misc
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	// Reset for eight cycles, then every scenario in turn.
	initial begin
		{rst_n_i, op_valid_i, bit_sel_i, imm_i, err_count, n_checks} = '0;
		{e_acc, e_flg, mem_load, mem_seed} = '0;
		op_i = rssd_pkg::OP_NONE;
		repeat (8) @(posedge mclk_i);
		chk("reset state", 8'h00, {accum_o[3:0], carry_o, zero_o, busy_o, mem_we_o});
		#1;
		rst_n_i = 1'b1;
		repeat (3) @(posedge mclk_i);
		t_rot();
		t_sub();
		t_skip();
		t_misc();
		t_refuse();
		stop_test();
	end
endmodule : testbench
bind rssd_datapath rssd_chk_sva i_chk (.mclk_i, .rst_n_i, .op_valid_i, .op_i, .bit_sel_i,
	.imm_i, .mem_rdata_i, .mem_we_o, .mem_wdata_o, .accum_o, .carry_o, .nibble_half_flag_o,
	.signed_range_flag_o, .zero_o, .busy_o, .skip_next_o);
